// ---- src/dpg_consts.svh ----
`ifndef DPG_CONSTS_SVH
`define DPG_CONSTS_SVH

// register addresses on the APB bus; DPG_MAIN_GAIN_ADDR is a word address (0x1b4 >> 2), the rest are byte addresses
`define DPG_MAIN_GAIN_ADDR 12'h06d
`define DPG_MAIN_GAIN_BYTE_ADDR 12'h1b4
`define DPG_AUX_GAIN_ADDR 12'h1b8
`define DPG_MAIN_DAMP_ADDR 12'h1bc
`define DPG_MODE_ADDR 12'h1c0
`define DPG_SEL_ADDR 12'h1c4

// gain register fields
`define DPG_EN_BIT 7
`define DPG_HF_MSB 6
`define DPG_HF_LSB 4
`define DPG_DIG_MSB 2
`define DPG_DIG_LSB 0
`define DPG_GAIN_WMASK 8'hf7

// damping register fields
`define DPG_LF_MSB 6
`define DPG_LF_LSB 4
`define DPG_DAMP_WMASK 8'h77

// reset values
`define DPG_MAIN_GAIN_RST 8'hc2
`define DPG_AUX_GAIN_RST 8'hc2
`define DPG_MAIN_DAMP_RST 8'h13

`endif

// ---- src/dpg_pkg.sv ----
package dpg_pkg;

    typedef enum logic [1:0] {
        DPG_LOCK_DIGITAL = 2'b00,
        DPG_LOCK_ANALOG_HF = 2'b01,
        DPG_LOCK_ANALOG_8K = 2'b10,
        DPG_LOCK_NONE = 2'b11
    } dpg_lock_mode_type;

endpackage : dpg_pkg

// ---- src/dpg_gain_sel.sv ----
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_gain_sel (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] gain_cfg,
    input wire logic [2:0] lf_gain,
    input wire dpg_pkg::dpg_lock_mode_type mode,
    output logic pd2_en,
    output logic [2:0] pd2_gain
);
    import dpg_pkg::*;

    logic en_d;
    logic [2:0] gain_d;

    always_comb begin
        en_d = 1'b0;
        gain_d = 3'h0;
        if (gain_cfg[`DPG_EN_BIT]) begin
            unique case (mode)
                DPG_LOCK_DIGITAL: begin
                    en_d = 1'b1;
                    gain_d = gain_cfg[`DPG_DIG_MSB:`DPG_DIG_LSB];
                end
                DPG_LOCK_ANALOG_HF: begin
                    en_d = 1'b1;
                    gain_d = gain_cfg[`DPG_HF_MSB:`DPG_HF_LSB];
                end
                DPG_LOCK_ANALOG_8K: begin
                    en_d = 1'b1;
                    gain_d = lf_gain;
                end
                DPG_LOCK_NONE: begin
                    en_d = 1'b0;
                    gain_d = 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pd2_en <= 1'b0;
            pd2_gain <= 3'h0;
        end else begin
            pd2_en <= en_d;
            pd2_gain <= gain_d;
        end
    end

endmodule : dpg_gain_sel

// ---- src/dpg_gain_bank.sv ----
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_gain_bank (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dpg_pkg::dpg_lock_mode_type main_mode,
    input wire dpg_pkg::dpg_lock_mode_type aux_mode,
    output logic main_pd2_en,
    output logic [2:0] main_pd2_gain,
    output logic aux_pd2_en,
    output logic [2:0] aux_pd2_gain
);
    import dpg_pkg::*;

    logic [7:0] main_gain_q;
    logic [7:0] aux_gain_q;
    logic [7:0] main_damp_q;
    logic [31:0] rdata_d;
    logic hit_d;
    logic wr_en;

    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;

    always_comb begin
        hit_d = 1'b1;
        rdata_d = 32'h0;
        unique case (paddr)
            `DPG_MAIN_GAIN_BYTE_ADDR: rdata_d = {24'h0, main_gain_q};
            `DPG_AUX_GAIN_ADDR: rdata_d = {24'h0, aux_gain_q};
            `DPG_MAIN_DAMP_ADDR: rdata_d = {24'h0, main_damp_q};
            `DPG_MODE_ADDR: rdata_d = {28'h0, aux_mode, main_mode};
            `DPG_SEL_ADDR: begin
                rdata_d = {20'h0, aux_pd2_en, aux_pd2_gain,
                           main_pd2_en, 4'h0, main_pd2_gain};
                rdata_d[7:4] = 4'h0;
                rdata_d[7] = main_pd2_en;
                rdata_d[2:0] = main_pd2_gain;
                rdata_d[11:8] = {aux_pd2_en, aux_pd2_gain};
                rdata_d[6:3] = 4'h0;
            end
            default: hit_d = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error, reads return zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    assign pslverr = psel & penable & ~hit_d;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            main_gain_q <= `DPG_MAIN_GAIN_RST;
        end else if (wr_en && paddr == `DPG_MAIN_GAIN_BYTE_ADDR) begin
            main_gain_q <= pwdata[7:0] & `DPG_GAIN_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aux_gain_q <= `DPG_AUX_GAIN_RST;
        end else if (wr_en && paddr == `DPG_AUX_GAIN_ADDR) begin
            aux_gain_q <= pwdata[7:0] & `DPG_GAIN_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            main_damp_q <= `DPG_MAIN_DAMP_RST;
        end else if (wr_en && paddr == `DPG_MAIN_DAMP_ADDR) begin
            main_damp_q <= pwdata[7:0] & `DPG_DAMP_WMASK;
        end
    end

    dpg_gain_sel u_main_sel (
        .mclk(mclk),
        .reset_n(reset_n),
        .gain_cfg(main_gain_q),
        .lf_gain(main_damp_q[`DPG_LF_MSB:`DPG_LF_LSB]),
        .mode(main_mode),
        .pd2_en(main_pd2_en),
        .pd2_gain(main_pd2_gain)
    );

    // aux path has no separate 8 kHz field; it reuses its high-rate gain
    dpg_gain_sel u_aux_sel (
        .mclk(mclk),
        .reset_n(reset_n),
        .gain_cfg(aux_gain_q),
        .lf_gain(aux_gain_q[`DPG_HF_MSB:`DPG_HF_LSB]),
        .mode(aux_mode),
        .pd2_en(aux_pd2_en),
        .pd2_gain(aux_pd2_gain)
    );

endmodule : dpg_gain_bank

// ---- dv/dpg_gain_bank_chk.sv ----
`timescale 1ns/1ns
module dpg_chk (
    input wire logic mclk, reset_n, psel, penable, pwrite, pready,
    input wire logic pslverr, main_pd2_en,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic [2:0] main_pd2_gain,
    input wire dpg_pkg::dpg_lock_mode_type main_mode
);
    import dpg_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_acc; psel && penable; endsequence
    sequence s_idle; !psel && $stable(main_mode); endsequence
    property p_rdy; s_acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("stall");
    property p_err; !penable |-> !pslverr; endproperty
    a_err: assert property (p_err) else $error("early error");
    property p_map; s_acc ##0 paddr == 12'h1b4 |-> !pslverr; endproperty
    a_map: assert property (p_map) else $error("refused");
    property p_bit3; s_acc ##0 !pwrite && paddr == 12'h1b4 |-> !prdata[3];
    endproperty
    a_bit3: assert property (p_bit3) else $error("bit 3 set");
    property p_off; main_mode == DPG_LOCK_NONE |=> !main_pd2_en; endproperty
    a_off: assert property (p_off) else $error("still on");
    property p_on; main_pd2_en |-> $past(main_mode) != DPG_LOCK_NONE;
    endproperty
    a_on: assert property (p_on) else $error("on unlocked");
    property p_dis; !main_pd2_en |-> main_pd2_gain == 3'h0; endproperty
    a_dis: assert property (p_dis) else $error("gain when off");
    property p_hold; s_idle ##1 s_idle |=> $stable(main_pd2_gain); endproperty
    a_hold: assert property (p_hold) else $error("gain moved");
endmodule : dpg_chk
bind dpg_gain_bank dpg_chk u_chk (.*);

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import dpg_pkg::*;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, er, main_pd2_en, aux_pd2_en;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0] main_pd2_gain, aux_pd2_gain;
    dpg_lock_mode_type main_mode = DPG_LOCK_NONE;
    dpg_lock_mode_type aux_mode = DPG_LOCK_DIGITAL;
    int n_checks, n_mismatch, cyc;
    wire [3:0] msel = {main_pd2_en, main_pd2_gain};
    dpg_gain_bank u_dut (.*);
    always #50 mclk = ~mclk;
    task final_report;
        $display("checks %0d errors %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    always @(posedge mclk) if (++cyc == 500) begin
        n_mismatch++;
        final_report;
    end
    task chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %0t %h", $time, got);
        end
    endtask : chk
    task xfer(input logic w, input logic [11:0] a, d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
    task t_regs;
        xfer(0, 12'h1b4, 0);
        chk(rd, 32'hc2);
        xfer(1, 12'h1b8, 12'hff);
        xfer(0, 12'h1b8, 0);
        chk(rd, 32'hf7);
        xfer(0, 12'h200, 0);
        chk({er, rd[30:0]}, 32'h80000000);
    endtask : t_regs
    task t_select;
        logic [15:0] m = 16'h0fad;
        xfer(1, 12'h1b4, 12'ha5);
        xfer(1, 12'h1bc, 12'h73);
        for (int i = 0; i < 4; i++) begin
            main_mode <= dpg_lock_mode_type'(i[1:0]);
            repeat (2) @(posedge mclk);
            chk(32'(msel), 32'(m[4*i +: 4]));
        end
        xfer(1, 12'h1b4, 12'h25);
        main_mode <= DPG_LOCK_ANALOG_HF;
        repeat (2) @(posedge mclk);
        chk(32'(msel), 32'h0);
    endtask : t_select
    task t_aux;
        xfer(1, 12'h1b8, 12'he1);
        aux_mode <= DPG_LOCK_ANALOG_8K;
        repeat (2) @(posedge mclk);
        chk(32'({aux_pd2_en, aux_pd2_gain}), 32'he);
        aux_mode <= DPG_LOCK_DIGITAL;
        repeat (2) @(posedge mclk);
        chk(32'({aux_pd2_en, aux_pd2_gain}), 32'h9);
        xfer(0, 12'h1c4, 0);
        chk(rd, 32'h900);
        xfer(0, 12'h1bc, 0);
        chk(rd, 32'h73);
        xfer(0, 12'h1c0, 0);
        chk(rd, 32'h1);
    endtask : t_aux
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'h1;
        t_regs;
        t_select;
        t_aux;
        final_report;
    end
endmodule : tb_top
